// *** rtl/rsdc_ctrl.sv ***
// Purpose: Reset combination, brownout handling, code protection and debug gating
// Assumes: All inputs synchronous to pclk; pattern word valid while pattern_valid
// Notes:   One APB slave, zero wait states
// ==========================================================================
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rsdc_ctrl
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire rsdc_pkg::rsdc_src_t src,
  input  wire logic              supply_ok,
  input  wire logic [31:0]       protect_word,
  input  wire logic              pattern_valid,
  input  wire logic              boot_select_pin,
  input  wire logic              iap_request,
  output logic                   chip_reset,
  output logic                   osc_start,
  output logic                   flash_init,
  output logic                   bod_irq,
  output logic                   bod_irq_to_cpu,
  output logic                   swd_enable,
  output logic                   scan_mode,
  output logic                   isp_enter,
  output logic                   iap_grant,
  output var rsdc_pkg::rsdc_prog_t prog_allow,
  output logic      [7:0]        gpio_edge_sel,
  output logic      [31:0]       fetch_addr
);

  // ==========================================================================
  // Helpers
  function automatic rsdc_pkg::rsdc_level_t decode_level(input logic [31:0] w);
    rsdc_pkg::rsdc_level_t l;
    l = rsdc_pkg::RSDC_LVL_NONE;
    if (w == rsdc_pkg::PAT_LEVEL_ONE)
      l = rsdc_pkg::RSDC_LVL_ONE;
    else if (w == rsdc_pkg::PAT_LEVEL_TWO)
      l = rsdc_pkg::RSDC_LVL_TWO;
    else if (w == rsdc_pkg::PAT_LEVEL_THREE)
      l = rsdc_pkg::RSDC_LVL_THREE;
    return l;
  endfunction : decode_level

  // Supply below threshold when the detected level index drops below selection
  function automatic logic below(input logic [1:0] meas, input logic [1:0] sel);
    return meas < sel;
  endfunction : below

  rsdc_pkg::rsdc_state_reg_t r;
  rsdc_pkg::rsdc_state_reg_t next_r;

  logic        wr_en;
  logic        rd_en;
  logic        bod_rst;
  logic        pin_reset;
  logic        any_src;
  logic [31:0] rd_val;

  // ==========================================================================
  // Next state
  always_comb
  begin
    next_r = r;
    wr_en  = psel && penable && pwrite;
    rd_en  = psel && !penable && !pwrite;

    bod_rst = r.ctrl[rsdc_pkg::CTRL_RST_EN_BIT] &&
              below(src.brownout_level, r.ctrl[rsdc_pkg::CTRL_RST_LVL_LSB +: 2]);

    // Short glitches are filtered: pin must stay low the full count
    if (!src.pin_n)
      next_r.low_cnt = (r.low_cnt == rsdc_pkg::PIN_LOW_CNT) ? r.low_cnt : r.low_cnt + 4'h1;
    else
      next_r.low_cnt = 4'h0;
    pin_reset = (next_r.low_cnt == rsdc_pkg::PIN_LOW_CNT);

    any_src = pin_reset || src.watchdog || src.power_on || bod_rst;

    unique case (r.state)
      rsdc_pkg::RSDC_ST_RESET:
      begin
        if (any_src)
          next_r.cnt = rsdc_pkg::RESET_STRETCH;
        else if (r.cnt != 4'h0)
          next_r.cnt = r.cnt - 4'h1;
        else if (supply_ok)
        begin
          next_r.state = rsdc_pkg::RSDC_ST_START;
          next_r.cnt   = rsdc_pkg::OSC_START_CY;
        end
      end
      rsdc_pkg::RSDC_ST_START:
      begin
        if (any_src)
        begin
          next_r.state = rsdc_pkg::RSDC_ST_RESET;
          next_r.cnt   = rsdc_pkg::RESET_STRETCH;
        end
        else if (r.cnt != 4'h0)
          next_r.cnt = r.cnt - 4'h1;
        else
          next_r.state = rsdc_pkg::RSDC_ST_RUN;
      end
      rsdc_pkg::RSDC_ST_RUN:
      begin
        if (any_src)
        begin
          next_r.state = rsdc_pkg::RSDC_ST_RESET;
          next_r.cnt   = rsdc_pkg::RESET_STRETCH;
        end
      end
      // The unused code falls back into reset rather than hanging
      default:
        next_r.state = rsdc_pkg::RSDC_ST_RESET;
    endcase

    next_r.chip_reset = (next_r.state != rsdc_pkg::RSDC_ST_RUN);
    // Oscillator starts and flash reinitialises once supply is usable
    next_r.osc_start  = (next_r.state == rsdc_pkg::RSDC_ST_START);
    next_r.flash_init = next_r.chip_reset && supply_ok;

    if (any_src)
    begin
      next_r.cause = {bod_rst, src.power_on, src.watchdog, pin_reset};
      // Software registers return to initial values inside reset
      next_r.ctrl      = rsdc_pkg::CTRL_RESET;
      next_r.gpio_edge = 8'h00;
    end

    // Protection level latched from the flash word during reset only
    if (next_r.chip_reset && pattern_valid)
    begin
      next_r.level        = decode_level(protect_word);
      next_r.boot_sel_off = (protect_word == rsdc_pkg::PAT_NO_BOOT_SEL);
    end

    next_r.prog.isp_full             = (r.level == rsdc_pkg::RSDC_LVL_NONE);
    next_r.prog.isp_partial          = (r.level == rsdc_pkg::RSDC_LVL_ONE);
    next_r.prog.isp_erase_all        = (r.level == rsdc_pkg::RSDC_LVL_TWO);
    next_r.prog.boot_select_honoured = (r.level != rsdc_pkg::RSDC_LVL_THREE) && !r.boot_sel_off;

    // Debug only out of reset, pin high, and no protection
    next_r.swd_enable = !next_r.chip_reset && src.pin_n &&
                        (r.level == rsdc_pkg::RSDC_LVL_NONE);
    next_r.scan_mode  = !src.pin_n;

    next_r.bod_irq = below(src.brownout_level, r.ctrl[rsdc_pkg::CTRL_INT_LVL_LSB +: 2]);
    // Status sees the raw request; only the enabled copy goes on to the processor
    next_r.bod_irq_cpu = next_r.bod_irq && r.ctrl[rsdc_pkg::CTRL_INT_EN_BIT];

    // Registered so that every output except pslverr and fetch_addr leaves a flip-flop
    next_r.isp_enter = r.prog.boot_select_honoured && next_r.chip_reset && boot_select_pin;
    next_r.iap_grant = iap_request && !next_r.chip_reset;

    if (wr_en && !any_src)
    begin
      if (paddr == rsdc_pkg::OFF_CTRL)
        next_r.ctrl = pwdata[5:0];
      else if (paddr == rsdc_pkg::OFF_INTCFG)
        next_r.gpio_edge = pwdata[7:0];
    end

    unique case (paddr)
      rsdc_pkg::OFF_CTRL:   rd_val = {26'h0, r.ctrl};
      rsdc_pkg::OFF_STATUS: rd_val = {25'h0, r.boot_sel_off, r.level, r.swd_enable,
                                      r.scan_mode, r.chip_reset, r.bod_irq};
      rsdc_pkg::OFF_RSTSRC: rd_val = {28'h0, r.cause};
      rsdc_pkg::OFF_INTCFG: rd_val = {24'h0, r.gpio_edge};
      rsdc_pkg::OFF_DBGCAP: rd_val = {24'h0, rsdc_pkg::DBG_WATCHPTS, rsdc_pkg::DBG_BREAKPTS};
      default:              rd_val = 32'h0;
    endcase
    if (rd_en)
      next_r.prdata = rd_val;
    next_r.pready = 1'b1;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r              <= '0;
      r.state        <= rsdc_pkg::RSDC_ST_RESET;
      r.cnt          <= rsdc_pkg::RESET_STRETCH;
      r.chip_reset   <= 1'b1;
      r.level        <= rsdc_pkg::RSDC_LVL_NONE;
    end
    else
      r <= next_r;
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops except the constant pslverr and fetch_addr
  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = 1'b0;
  assign chip_reset     = r.chip_reset;
  assign osc_start      = r.osc_start;
  assign flash_init     = r.flash_init;
  assign bod_irq        = r.bod_irq;
  // Controller enable lives in the interrupt controller; here it is the ctrl bit
  assign bod_irq_to_cpu = r.bod_irq_cpu;
  assign swd_enable     = r.swd_enable;
  assign scan_mode      = r.scan_mode;
  // Boot-select entry sampled only while honoured
  assign isp_enter      = r.isp_enter;
  assign iap_grant      = r.iap_grant;
  assign prog_allow     = r.prog;
  assign gpio_edge_sel  = r.gpio_edge;
  assign fetch_addr     = rsdc_pkg::BOOT_ADDR;

  // ==========================================================================
  // Checks
  swd_in_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.chip_reset |-> !r.swd_enable) else $error("debug enabled in reset");
  swd_prot_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.level != rsdc_pkg::RSDC_LVL_NONE) |=> !r.swd_enable) else $error("debug with protection");
  pin_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!src.pin_n)[*2] |=> r.state == rsdc_pkg::RSDC_ST_RESET) else $error("pin low not reset");
  wdog_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    src.watchdog |=> r.chip_reset) else $error("watchdog not reset");
  osc_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r.osc_start) |-> r.chip_reset) else $error("oscillator start outside reset");
  scan_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    !src.pin_n |=> r.scan_mode && !r.swd_enable) else $error("scan select wrong");
  lvl3_boot_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.level == rsdc_pkg::RSDC_LVL_THREE) |=> !r.prog.boot_select_honoured) else $error("boot pin honoured");
  bod_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.ctrl[rsdc_pkg::CTRL_INT_EN_BIT] && below(src.brownout_level, r.ctrl[1:0]) && !src.power_on
     && !src.watchdog && src.pin_n && !r.ctrl[rsdc_pkg::CTRL_RST_EN_BIT]) |=> r.bod_irq)
    else $error("brownout interrupt missing");
  release_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(r.chip_reset) |-> r.ctrl == rsdc_pkg::CTRL_RESET) else $error("release with stale ctrl");

  // ==========================================================================
  // Reset sequencing checks

  run_no_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == rsdc_pkg::RSDC_ST_RUN) |-> !r.chip_reset) else $error("reset flag high in run");

  held_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state != rsdc_pkg::RSDC_ST_RUN) |-> r.chip_reset) else $error("reset flag low outside run");

  run_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == rsdc_pkg::RSDC_ST_RUN && any_src) |=> r.state == rsdc_pkg::RSDC_ST_RESET)
    else $error("source did not stop run");

  osc_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.osc_start |-> r.state == rsdc_pkg::RSDC_ST_START) else $error("oscillator start out of phase");

  flash_reinit_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.flash_init |-> r.chip_reset) else $error("flash init outside reset");

  no_supply_a: assert property (@(posedge pclk) disable iff (!presetn)
    !supply_ok |=> !r.flash_init) else $error("flash init without supply");

  supply_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == rsdc_pkg::RSDC_ST_RESET && !supply_ok) |=> r.state == rsdc_pkg::RSDC_ST_RESET)
    else $error("left reset without supply");

  por_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    src.power_on |=> r.chip_reset && r.state == rsdc_pkg::RSDC_ST_RESET)
    else $error("power-on not reset");

  bod_forced_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.ctrl[rsdc_pkg::CTRL_RST_EN_BIT] && below(src.brownout_level, r.ctrl[3:2])) |=> r.chip_reset)
    else $error("brownout reset missing");

  // ==========================================================================
  // Reset cause and initial value checks

  pin_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!src.pin_n)[*2] |=> r.cause[0]) else $error("pin cause missing");

  wdog_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    src.watchdog |=> r.cause[1]) else $error("watchdog cause missing");

  por_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    src.power_on |=> r.cause[2]) else $error("power-on cause missing");

  bod_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    bod_rst |=> r.cause[3]) else $error("brownout cause missing");

  ctrl_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    any_src |=> r.ctrl == rsdc_pkg::CTRL_RESET) else $error("ctrl kept through reset");

  edge_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    any_src |=> r.gpio_edge == 8'h00) else $error("edge select kept through reset");

  // ==========================================================================
  // Brownout interrupt checks

  irq_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    !below(src.brownout_level, r.ctrl[1:0]) |=> !r.bod_irq) else $error("brownout request spurious");

  cpu_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !r.ctrl[rsdc_pkg::CTRL_INT_EN_BIT] |=> !r.bod_irq_cpu) else $error("disabled request reached cpu");

  cpu_needs_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.bod_irq_cpu |-> r.bod_irq) else $error("cpu request without source");

  // ==========================================================================
  // Protection and debug checks

  level_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!r.chip_reset ##1 !r.chip_reset) |-> $stable(r.level)) else $error("level changed in run");

  lvl1_prog_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.level == rsdc_pkg::RSDC_LVL_ONE) |=> r.prog.isp_partial && !r.prog.isp_full && !r.prog.isp_erase_all)
    else $error("level one command set wrong");

  lvl2_prog_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.level == rsdc_pkg::RSDC_LVL_TWO) |=> r.prog.isp_erase_all && !r.prog.isp_full && !r.prog.isp_partial)
    else $error("level two command set wrong");

  lvl3_prog_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.level == rsdc_pkg::RSDC_LVL_THREE) |=> !r.prog.isp_full && !r.prog.isp_partial && !r.prog.isp_erase_all)
    else $error("level three allows programming");

  no_boot_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.boot_sel_off |=> !r.prog.boot_select_honoured) else $error("disabled boot pin honoured");

  isp_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    !r.prog.boot_select_honoured |=> !r.isp_enter) else $error("boot pin entered programming");

  iap_grant_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.iap_grant |-> !r.chip_reset) else $error("application programming in reset");

  wdog_swd_a: assert property (@(posedge pclk) disable iff (!presetn)
    src.watchdog |=> !r.swd_enable) else $error("debug on during watchdog reset");

  scan_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    src.pin_n |=> !r.scan_mode) else $error("scan with pin high");

  dbgcap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == rsdc_pkg::OFF_DBGCAP) |=>
    r.prdata == {24'h0, rsdc_pkg::DBG_WATCHPTS, rsdc_pkg::DBG_BREAKPTS})
    else $error("debug capability wrong");

endmodule : rsdc_ctrl

`default_nettype wire

// *** rtl/rsdc_pkg.sv ***
// Purpose: Constants and types for the reset, security and debug control block
// Assumes: APB slave with 32-bit data, 25 MHz pclk
// Notes:   Register offsets are byte addresses
package rsdc_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned PIN_MIN_LOW_NS = 50;
  // Least time rounds up, never below one cycle
  localparam int unsigned PIN_MIN_LOW_CY_RAW = (PIN_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PIN_MIN_LOW_CY = (PIN_MIN_LOW_CY_RAW < 1) ? 1 : PIN_MIN_LOW_CY_RAW;
  localparam logic [3:0]  PIN_LOW_CNT    = 4'(PIN_MIN_LOW_CY);
  localparam logic [3:0]  RESET_STRETCH  = 4'h8;
  localparam logic [3:0]  OSC_START_CY   = 4'h4;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RSTSRC = 8'h08;
  localparam logic [7:0] OFF_INTCFG = 8'h0C;
  localparam logic [7:0] OFF_DBGCAP = 8'h10;

  // Control field positions
  localparam int CTRL_INT_LVL_LSB = 0;
  localparam int CTRL_RST_LVL_LSB = 2;
  localparam int CTRL_RST_EN_BIT  = 4;
  localparam int CTRL_INT_EN_BIT  = 5;

  localparam logic [5:0]  CTRL_RESET   = 6'h00;
  localparam logic [3:0]  DBG_BREAKPTS = 4'h4;
  localparam logic [3:0]  DBG_WATCHPTS = 4'h2;
  localparam logic [31:0] BOOT_ADDR    = 32'h0000_0000;

  // Protection patterns at the dedicated flash word
  localparam logic [31:0] PAT_NO_BOOT_SEL = 32'h4E69_7370;
  localparam logic [31:0] PAT_LEVEL_ONE   = 32'h1234_5678;
  localparam logic [31:0] PAT_LEVEL_TWO   = 32'h8765_4321;
  localparam logic [31:0] PAT_LEVEL_THREE = 32'h4321_8765;

  typedef enum logic [1:0]
  {
    RSDC_LVL_NONE  = 2'h0,
    RSDC_LVL_ONE   = 2'h1,
    RSDC_LVL_TWO   = 2'h2,
    RSDC_LVL_THREE = 2'h3
  } rsdc_level_t;

  // Gray along reset -> oscillator start -> run
  typedef enum logic [1:0]
  {
    RSDC_ST_RESET = 2'b00,
    RSDC_ST_START = 2'b01,
    RSDC_ST_RUN   = 2'b11
  } rsdc_state_t;

  typedef struct packed
  {
    logic       pin_n;
    logic       watchdog;
    logic       power_on;
    logic [1:0] brownout_level;
  } rsdc_src_t;

  typedef struct packed
  {
    logic       isp_full;
    logic       isp_partial;
    logic       isp_erase_all;
    logic       boot_select_honoured;
  } rsdc_prog_t;

  typedef struct packed
  {
    rsdc_state_t state;
    logic [3:0]  cnt;
    logic [3:0]  low_cnt;
    logic [5:0]  ctrl;
    logic [3:0]  cause;
    logic        bod_irq;
    logic        bod_irq_cpu;
    logic        isp_enter;
    logic        iap_grant;
    logic        chip_reset;
    logic        osc_start;
    logic        flash_init;
    logic        swd_enable;
    logic        scan_mode;
    rsdc_level_t level;
    logic        boot_sel_off;
    rsdc_prog_t  prog;
    logic [7:0]  gpio_edge;
    logic [31:0] prdata;
    logic        pready;
  } rsdc_state_reg_t;

endpackage : rsdc_pkg

// *** tb/rsdc_tester.sv ***
// Purpose: Far-side model: reset pin source and boundary-scan tester
// Assumes: pclk comes from the bench
// Notes:   Pin has a pull-up, so it idles high
`timescale 1ns/100ps
`default_nettype none
module rsdc_tester
#(
  parameter int SETTLE_CY = 20
)
(
  input  wire logic pclk,
  output logic      pin_n
);
  initial pin_n = 1'b1;
  // ========
  // Pin sequences
  task pulse(input int n);
    @(posedge pclk);
    pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    pin_n <= 1'b1;
  endtask : pulse
  // Settling time shortened from the full figure to keep the run brief
  task scan(input int n);
    repeat (SETTLE_CY) @(posedge pclk);
    pulse(n);
  endtask : scan
endmodule : rsdc_tester
`default_nettype wire

// *** tb/test_reset_security_debug_control.sv ***
// Purpose: Self-checking bench for the reset, security and debug control block
// Assumes: Zero-wait APB slave, reset pin on src.pin_n
// Notes:   Expected values come from the bench's own level table
`timescale 1ns/100ps
`default_nettype none
module test_reset_security_debug_control;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_n;
  logic [7:0]           paddr, gpio_edge_sel;
  logic [31:0]          pwdata, prdata, fetch_addr, q, r, protect_word;
  logic [1:0]           hi, bl;
  logic [2:0]           seen;
  logic                 supply_ok;
  logic                 pattern_valid, boot_select_pin, iap_request, chip_reset, osc_start, flash_init;
  logic                 bod_irq, bod_irq_to_cpu, swd_enable, scan_mode, isp_enter, iap_grant, hon;
  rsdc_pkg::rsdc_prog_t prog_allow;
  int                   n_errors, n_checks, cyc, lv [5];
  logic [31:0]          pats [5];

  rsdc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src({pin_n, hi, bl}), .supply_ok(supply_ok), .protect_word(protect_word), .pattern_valid(pattern_valid),
    .boot_select_pin(boot_select_pin), .iap_request(iap_request), .chip_reset(chip_reset),
    .osc_start(osc_start), .flash_init(flash_init), .bod_irq(bod_irq), .bod_irq_to_cpu(bod_irq_to_cpu),
    .swd_enable(swd_enable), .scan_mode(scan_mode), .isp_enter(isp_enter), .iap_grant(iap_grant),
    .prog_allow(prog_allow), .gpio_edge_sel(gpio_edge_sel), .fetch_addr(fetch_addr));
  rsdc_tester #(.SETTLE_CY(20)) i_src (.pclk(pclk), .pin_n(pin_n));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ========
  // Checks and bus cycles
  task test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 16)
    begin
      @(posedge pclk);
      t++;
    end
    if (t >= 16)
    begin
      n_errors++;
      test_done();
    end
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  // Waits for reset, oscillator start and run, noting what was seen on the way
  task wait_run;
    int t;
    t = 0;
    seen = 3'b000;
    while (!(seen[2] && !osc_start && !chip_reset) && t < 80)
    begin
      @(posedge pclk);
      seen = seen | {osc_start, flash_init, chip_reset};
      t++;
    end
    chk(seen, 3'b111);
    chk(fetch_addr, rsdc_pkg::BOOT_ADDR);
  endtask : wait_run
  task wait_rst;
    int t;
    t = 0;
    while (chip_reset !== 1'b1 && t < 8)
    begin
      @(posedge pclk);
      t++;
    end
  endtask : wait_rst

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_errors++;
      test_done();
    end
  end
  // ========
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, hi, bl} = {1'b0, 43'h0, 2'b00, 2'h3};
    supply_ok = 1'b1;
    {pattern_valid, boot_select_pin, iap_request, protect_word, cyc} = 0;
    pats = '{32'h0, rsdc_pkg::PAT_NO_BOOT_SEL, rsdc_pkg::PAT_LEVEL_ONE, rsdc_pkg::PAT_LEVEL_TWO,
      rsdc_pkg::PAT_LEVEL_THREE};
    lv = '{0, 0, 1, 2, 3};
    void'($urandom(32'h4F8EBCAD));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    chk({swd_enable, scan_mode}, 2'b10);
    apb(0, rsdc_pkg::OFF_DBGCAP, 0);
    chk(q, {24'h0, rsdc_pkg::DBG_WATCHPTS, rsdc_pkg::DBG_BREAKPTS});
    apb(0, 8'h14, 0);
    chk({q, pslverr}, 33'h0);
    apb(0, rsdc_pkg::OFF_CTRL, 0);
    chk(q, 32'(rsdc_pkg::CTRL_RESET));
    r = $urandom;
    apb(1, rsdc_pkg::OFF_INTCFG, r);
    apb(0, rsdc_pkg::OFF_INTCFG, 0);
    chk({q, gpio_edge_sel}, {24'h0, r[7:0], r[7:0]});
    // One cycle low is shorter than the least pulse and must not reset
    i_src.pulse(1);
    repeat (4) @(posedge pclk);
    chk(chip_reset, 0);
    i_src.pulse(2);
    wait_run();
    apb(0, rsdc_pkg::OFF_RSTSRC, 0);
    chk(q[0], 1);
    for (int k = 0; k < 2; k++)
    begin
      hi <= 2'b10 >> k;
      repeat (2) @(posedge pclk);
      hi <= 2'b00;
      wait_run();
      apb(0, rsdc_pkg::OFF_RSTSRC, 0);
      chk(q[k+1], 1);
    end
    fork
      i_src.scan(6);
      begin
        repeat (25) @(posedge pclk);
        chk({scan_mode, swd_enable}, 2'b10);
      end
    join
    wait_run();
    for (int s = 0; s < 8; s++)
    begin
      bl <= 2'($urandom_range(3));
      apb(1, rsdc_pkg::OFF_CTRL, {26'h0, s[2], 3'h0, s[1:0]});
      @(posedge pclk);
      apb(0, rsdc_pkg::OFF_STATUS, 0);
      chk(q[0], bl < s[1:0]);
      chk(bod_irq_to_cpu, (bl < s[1:0]) & s[2]);
    end
    bl <= 2'h3;
    apb(1, rsdc_pkg::OFF_CTRL, 32'h18);
    bl <= 2'h1;
    wait_rst();
    chk(chip_reset, 1);
    bl <= 2'h3;
    wait_run();
    apb(0, rsdc_pkg::OFF_RSTSRC, 0);
    chk(q[3], 1);
    {boot_select_pin, iap_request, pattern_valid} <= 3'b111;
    for (int i = 0; i < 5; i++)
    begin
      protect_word <= pats[i];
      i_src.pulse(2);
      hon = (lv[i] != 3) && (i != 1);
      // Boot-select entry only counts while the chip is still in reset
      repeat (3) @(posedge pclk);
      chk(isp_enter, hon);
      wait_run();
      chk(swd_enable, lv[i] == 0);
      chk(prog_allow, {lv[i] == 0, lv[i] == 1, lv[i] == 2, hon});
      chk({isp_enter, iap_grant}, {1'b0, 1'b1});
      apb(0, rsdc_pkg::OFF_STATUS, 0);
      chk(q[5:4], lv[i]);
    end
    // Without a usable supply the chip stays in reset and flash is left alone
    supply_ok <= 1'b0;
    i_src.pulse(2);
    repeat (20) @(posedge pclk);
    chk({chip_reset, flash_init, osc_start}, 3'b100);
    {supply_ok, iap_request, boot_select_pin} <= 3'b100;
    wait_run();
    chk(iap_grant, 0);
    test_done();
  end
endmodule : test_reset_security_debug_control
`default_nettype wire
